/* File: rtl/pdsc_port_drive_slew_control.sv */
// port drive type and slew rate control with axi4-lite registers
`timescale 1ns/10ps
module pdsc_port_drive_slew_control #(
    parameter int PINS = 6
) (
    // clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // axi4-lite write address
    input  wire logic [11:0]       s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    // axi4-lite write response
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // axi4-lite read address
    input  wire logic [11:0]       s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    // axi4-lite read data
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // pad side
    input  wire logic [PINS-1:0]   port_a_pins_in,
    output logic [PINS-1:0]        port_a_pin_out,
    output logic [PINS-1:0]        port_a_pin_oe_n,
    output logic [PINS-1:0]        slew_limit_select,
    output logic [PINS-1:0]        open_drain_select
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // keeps only implemented positions
    function automatic logic [7:0] impl_bits(input logic [7:0] v);
        impl_bits = v & pdsc_pkg::IMPL_MASK;
    endfunction

    // maps 8-bit register layout onto the six physical pins
    // pin i follows register bit i; pin 3 has no control, so stays zero
    function automatic logic [PINS-1:0] to_pins(input logic [7:0] v);
        logic [7:0] k;
        k = impl_bits(v);
        to_pins = PINS'(k);
    endfunction

    function automatic logic [7:0] from_pins(input logic [PINS-1:0] p);
        logic [5:0] q;
        q = 6'(p);
        from_pins = {2'b00, q[5:4], 1'b0, q[2:0]};
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [7:0]       drive_r,  drive_nxt;
    logic [7:0]       slew_r,   slew_nxt;
    logic [7:0]       out_r,    out_nxt;
    logic             awready_r, awready_nxt;
    logic             wready_r,  wready_nxt;
    logic             aw_held_r, aw_held_nxt;
    logic             w_held_r,  w_held_nxt;
    logic [11:0]      awaddr_r,  awaddr_nxt;
    logic [31:0]      wdata_r,   wdata_nxt;
    logic             wstrb0_r,  wstrb0_nxt;
    logic             bvalid_r,  bvalid_nxt;
    logic [1:0]       bresp_r,   bresp_nxt;
    logic             arready_r, arready_nxt;
    logic             rvalid_r,  rvalid_nxt;
    logic [31:0]      rdata_r,   rdata_nxt;
    logic [1:0]       rresp_r,   rresp_nxt;
    logic [PINS-1:0]  pin_meta_r, pin_sync_r;
    logic [PINS-1:0]  pad_out_r,  pad_out_nxt;
    logic [PINS-1:0]  pad_oen_r,  pad_oen_nxt;
    logic [PINS-1:0]  slew_o_r,   slew_o_nxt;
    logic [PINS-1:0]  od_o_r,     od_o_nxt;

    // ------------------------------------------------------------
    // write channel
    // ------------------------------------------------------------
    always_comb begin
        logic        aw_take;
        logic        w_take;
        logic        do_wr;
        logic [11:0] a;
        logic [31:0] d;
        logic        s0;
        aw_take     = s_axi_awvalid && awready_r;
        w_take      = s_axi_wvalid && wready_r;
        // halves taken this cycle count as held
        a           = aw_take ? s_axi_awaddr : awaddr_r;
        d           = w_take ? s_axi_wdata : wdata_r;
        s0          = w_take ? s_axi_wstrb[0] : wstrb0_r;
        // both halves present and no response pending
        do_wr       = (aw_held_r || aw_take) && (w_held_r || w_take)
                      && !bvalid_r;
        aw_held_nxt = aw_held_r || aw_take;
        w_held_nxt  = w_held_r || w_take;
        awaddr_nxt  = a;
        wdata_nxt   = d;
        wstrb0_nxt  = s0;
        drive_nxt   = drive_r;
        slew_nxt    = slew_r;
        out_nxt     = out_r;
        bvalid_nxt  = bvalid_r && !s_axi_bready;
        bresp_nxt   = bresp_r;
        if (do_wr) begin
            aw_held_nxt = 1'b0;
            w_held_nxt  = 1'b0;
            bvalid_nxt  = 1'b1;
            bresp_nxt   = pdsc_pkg::RESP_OKAY;
            unique case (a)
                pdsc_pkg::ADDR_DRIVE_TYPE: begin
                    if (s0) drive_nxt = impl_bits(d[7:0]);
                end
                pdsc_pkg::ADDR_SLEW_LIMIT: begin
                    if (s0) slew_nxt = impl_bits(d[7:0]);
                end
                pdsc_pkg::ADDR_PORT_OUT: begin
                    if (s0) out_nxt = impl_bits(d[7:0]);
                end
                pdsc_pkg::ADDR_PAD_STATUS: begin
                    bresp_nxt = pdsc_pkg::RESP_SLVERR;
                end
                default: begin
                    bresp_nxt = pdsc_pkg::RESP_SLVERR;
                end
            endcase
        end
        // accept a new half only while its slot is free
        awready_nxt = !aw_held_nxt;
        wready_nxt  = !w_held_nxt;
    end

    // ------------------------------------------------------------
    // read channel
    // ------------------------------------------------------------
    always_comb begin
        logic ar_take;
        ar_take     = s_axi_arvalid && arready_r;
        rvalid_nxt  = rvalid_r && !s_axi_rready;
        rdata_nxt   = rdata_r;
        rresp_nxt   = rresp_r;
        if (ar_take) begin
            rvalid_nxt = 1'b1;
            rresp_nxt  = pdsc_pkg::RESP_OKAY;
            unique case (s_axi_araddr)
                pdsc_pkg::ADDR_DRIVE_TYPE:
                    rdata_nxt = {24'h00_0000, impl_bits(drive_r)};
                pdsc_pkg::ADDR_SLEW_LIMIT:
                    rdata_nxt = {24'h00_0000, impl_bits(slew_r)};
                pdsc_pkg::ADDR_PORT_OUT:
                    rdata_nxt = {24'h00_0000, out_r};
                pdsc_pkg::ADDR_PAD_STATUS:
                    rdata_nxt = {24'h00_0000, from_pins(pin_sync_r)};
                default: begin
                    rdata_nxt = 32'h0000_0000;
                    rresp_nxt = pdsc_pkg::RESP_SLVERR;
                end
            endcase
        end
        // one read in flight: ready only while no answer stands
        arready_nxt = !rvalid_nxt;
    end

    // ------------------------------------------------------------
    // pad control
    // ------------------------------------------------------------
    always_comb begin
        logic [PINS-1:0] od;
        logic [PINS-1:0] lvl;
        od          = to_pins(drive_r);
        lvl         = to_pins(out_r);
        od_o_nxt    = od;
        slew_o_nxt  = to_pins(slew_r);
        pad_out_nxt = lvl & ~od;
        for (int i = 0; i < PINS; i++) begin
            if (od[i]) begin
                // open-drain: drive low for zero, release for one
                pad_oen_nxt[i] = lvl[i];
            end else begin
                pad_oen_nxt[i] = 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            drive_r    <= pdsc_pkg::DRIVE_RST;
            slew_r     <= pdsc_pkg::SLEW_RST;
            out_r      <= pdsc_pkg::PORT_OUT_RST;
            awready_r  <= 1'b0;
            wready_r   <= 1'b0;
            aw_held_r  <= 1'b0;
            w_held_r   <= 1'b0;
            awaddr_r   <= 12'h000;
            wdata_r    <= 32'h0000_0000;
            wstrb0_r   <= 1'b0;
            bvalid_r   <= 1'b0;
            bresp_r    <= pdsc_pkg::RESP_OKAY;
            arready_r  <= 1'b0;
            rvalid_r   <= 1'b0;
            rdata_r    <= 32'h0000_0000;
            rresp_r    <= pdsc_pkg::RESP_OKAY;
            pin_meta_r <= '0;
            pin_sync_r <= '0;
            pad_out_r  <= '0;
            pad_oen_r  <= '1;
            slew_o_r   <= '1;
            od_o_r     <= '0;
        end else begin
            drive_r    <= drive_nxt;
            slew_r     <= slew_nxt;
            out_r      <= out_nxt;
            awready_r  <= awready_nxt;
            wready_r   <= wready_nxt;
            aw_held_r  <= aw_held_nxt;
            w_held_r   <= w_held_nxt;
            awaddr_r   <= awaddr_nxt;
            wdata_r    <= wdata_nxt;
            wstrb0_r   <= wstrb0_nxt;
            bvalid_r   <= bvalid_nxt;
            bresp_r    <= bresp_nxt;
            arready_r  <= arready_nxt;
            rvalid_r   <= rvalid_nxt;
            rdata_r    <= rdata_nxt;
            rresp_r    <= rresp_nxt;
            // pins are asynchronous: two stages before use
            pin_meta_r <= port_a_pins_in;
            pin_sync_r <= pin_meta_r;
            pad_out_r  <= pad_out_nxt;
            pad_oen_r  <= pad_oen_nxt;
            slew_o_r   <= slew_o_nxt;
            od_o_r     <= od_o_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign s_axi_awready     = awready_r;
    assign s_axi_wready      = wready_r;
    assign s_axi_bvalid      = bvalid_r;
    assign s_axi_bresp       = bresp_r;
    assign s_axi_arready     = arready_r;
    assign s_axi_rvalid      = rvalid_r;
    assign s_axi_rdata       = rdata_r;
    assign s_axi_rresp       = rresp_r;
    assign port_a_pin_out    = pad_out_r;
    assign port_a_pin_oe_n   = pad_oen_r;
    assign slew_limit_select = slew_o_r;
    assign open_drain_select = od_o_r;

endmodule

/* File: common/pdsc_pkg.sv */
// package for the port drive and slew control block
package pdsc_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [11:0] ADDR_DRIVE_TYPE = 12'h000;
    localparam logic [11:0] ADDR_SLEW_LIMIT = 12'h004;
    localparam logic [11:0] ADDR_PAD_STATUS = 12'h008;
    localparam logic [11:0] ADDR_PORT_OUT   = 12'h00c;

    // ------------------------------------------------------------
    // field layout and reset values
    // ------------------------------------------------------------
    localparam int          PIN_COUNT      = 6;
    localparam logic [7:0]  IMPL_MASK      = 8'h37;
    localparam logic [7:0]  DRIVE_RST      = 8'h00;
    localparam logic [7:0]  SLEW_RST       = 8'h37;
    localparam logic [7:0]  PORT_OUT_RST   = 8'h00;
    localparam logic [1:0]  RESP_OKAY      = 2'b00;
    localparam logic [1:0]  RESP_SLVERR    = 2'b10;

    // per-pin pad control carried to the pad ring
    typedef struct packed {
        logic open_drain_select;
        logic slew_limit_select;
        logic drive_low_n;
        logic out_level;
    } pdsc_pad_type;

endpackage

/* File: tb/pdsc_assertions.sv */
// concurrent checks on the drive and slew control block ports
`timescale 1ns/10ps
module pdsc_assertions #(
    parameter int PINS = 6
) (
    // clock and reset
    input wire logic            aclk,
    input wire logic            aresetn,
    // register bus
    input wire logic            s_axi_arvalid,
    input wire logic            s_axi_arready,
    input wire logic [31:0]     s_axi_rdata,
    input wire logic            s_axi_rvalid,
    input wire logic            s_axi_rready,
    input wire logic [1:0]      s_axi_bresp,
    input wire logic            s_axi_bvalid,
    input wire logic            s_axi_bready,
    // pad side
    input wire logic [PINS-1:0] port_a_pin_out,
    input wire logic [PINS-1:0] port_a_pin_oe_n,
    input wire logic [PINS-1:0] slew_limit_select,
    input wire logic [PINS-1:0] open_drain_select
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    od_sink_only_a: assert property (
        (open_drain_select & port_a_pin_out) == '0)
        else $error("open-drain pin driven high");
    // first edge after release still shows reset pad values
    pp_drives_a: assert property (
        $past(aresetn) |-> (~open_drain_select & port_a_pin_oe_n)
        == '0) else $error("push-pull pin not driven");
    reset_pads_a: assert property (
        $rose(aresetn) |=> slew_limit_select[2:0] == 3'h7
        && open_drain_select[2:0] == 3'h0) else $error("pad reset config");
    unimpl_zero_a: assert property (
        s_axi_rvalid |-> s_axi_rdata[31:6] == 26'h0 && !s_axi_rdata[3])
        else $error("unimplemented read bits set");
    read_answer_a: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    rdata_hold_a: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    bresp_hold_a: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    bresp_done_a: assert property (
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    cover property (s_axi_bvalid && s_axi_bready);
    cover property (s_axi_rvalid && s_axi_rready);
    cover property (open_drain_select[0] && port_a_pin_oe_n[0]);
endmodule

bind pdsc_port_drive_slew_control pdsc_assertions #(.PINS(PINS)) u_chk (
    .aclk, .aresetn, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rvalid, .s_axi_rready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .port_a_pin_out, .port_a_pin_oe_n, .slew_limit_select, .open_drain_select);

/* File: tb/tb.sv */
// self-checking bench for the port drive and slew control block
`timescale 1ns/10ps
module tb;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic        s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [5:0]  pins_in, pin_out, oe_n, slew, od;
    int          n_mismatch, comparisons;
    localparam logic [1:0] OK = pdsc_pkg::RESP_OKAY;
    localparam logic [1:0] ERR = pdsc_pkg::RESP_SLVERR;

    pdsc_port_drive_slew_control #(.PINS(6)) uut (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .port_a_pins_in(pins_in),
        .port_a_pin_out(pin_out), .port_a_pin_oe_n(oe_n),
        .slew_limit_select(slew), .open_drain_select(od));

    always #25 aclk = ~aclk;
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic final_report;
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] e, g);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic hung(input logic done);
        if (!done) begin
            n_mismatch++;
            final_report();
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        int n;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid && n < 40);
        s_axi_bready <= 1'h0;
        hung(s_axi_bvalid);
        check("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] ed,
                      input logic [1:0] er);
        int n;
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid && n < 40);
        s_axi_rready <= 1'h0;
        hung(s_axi_rvalid);
        check("rdata", ed, s_axi_rdata);
        check("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
    endtask
    // pads settle one edge after the write response
    task automatic pads(input logic [5:0] e_od, e_oe, e_out, e_slw);
        @(posedge aclk);
        #1;
        check("od", {26'h0, e_od}, {26'h0, od});
        check("oe_n", {26'h0, e_oe}, {26'h0, oe_n});
        check("out", {26'h0, e_out}, {26'h0, pin_out});
        check("slew", {26'h0, e_slw}, {26'h0, slew});
    endtask
    task automatic do_reset;
        @(posedge aclk);
        aresetn <= 1'h0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'h1;
        repeat (2) @(posedge aclk);
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic reset_defaults;
        rd(pdsc_pkg::ADDR_DRIVE_TYPE, 32'h0000_0000, OK);
        rd(pdsc_pkg::ADDR_SLEW_LIMIT, 32'h0000_0037, OK);
        pads(6'h00, 6'h00, 6'h00, 6'h37);
    endtask
    task automatic field_masking;
        wr(pdsc_pkg::ADDR_DRIVE_TYPE, 32'hffff_ffff, OK);
        rd(pdsc_pkg::ADDR_DRIVE_TYPE, 32'h0000_0037, OK);
        wr(pdsc_pkg::ADDR_SLEW_LIMIT, 32'h0000_0000, OK);
        rd(pdsc_pkg::ADDR_SLEW_LIMIT, 32'h0000_0000, OK);
        wr(pdsc_pkg::ADDR_SLEW_LIMIT, 32'h0000_00cd, OK);
        rd(pdsc_pkg::ADDR_SLEW_LIMIT, 32'h0000_0005, OK);
        pads(6'h37, 6'h00, 6'h00, 6'h05);
    endtask
    task automatic open_drain_levels;
        wr(pdsc_pkg::ADDR_DRIVE_TYPE, 32'h0000_0005, OK);
        wr(pdsc_pkg::ADDR_PORT_OUT, 32'h0000_0003, OK);
        pads(6'h05, 6'h01, 6'h02, 6'h05);
        wr(pdsc_pkg::ADDR_DRIVE_TYPE, 32'h0000_0000, OK);
        pads(6'h00, 6'h00, 6'h03, 6'h05);
        wr(pdsc_pkg::ADDR_DRIVE_TYPE, 32'h0000_0030, OK);
        wr(pdsc_pkg::ADDR_PORT_OUT, 32'h0000_0010, OK);
        pads(6'h30, 6'h10, 6'h00, 6'h05);
    endtask
    task automatic bad_access;
        rd(12'h010, 32'h0000_0000, ERR);
        wr(pdsc_pkg::ADDR_PAD_STATUS, 32'h0000_0000, ERR);
        rd(pdsc_pkg::ADDR_PAD_STATUS, 32'h0000_0035, OK);
    endtask
    task automatic mid_reset;
        wr(pdsc_pkg::ADDR_DRIVE_TYPE, 32'h0000_0037, OK);
        do_reset();
        reset_defaults();
    endtask

    initial begin
        aclk = 1'h0;
        aresetn = 1'h0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready} = 2'h0;
        s_axi_awaddr = 12'h000;
        s_axi_araddr = 12'h000;
        s_axi_wdata = 32'h0000_0000;
        s_axi_wstrb = 4'hf;
        pins_in = 6'h3d;
        n_mismatch = 0;
        comparisons = 0;
        do_reset();
        reset_defaults();
        field_masking();
        open_drain_levels();
        bad_access();
        mid_reset();
        final_report();
    end
endmodule
